//--- pkg/err_chk_regs.svh
// Purpose: Register offsets, reset values and limits of the error checker
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Included by bare name
`ifndef ERR_CHK_REGS_SVH
`define ERR_CHK_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFF_CTRL 12'h000
`define OFF_IRQ_STAT 12'h004
`define OFF_IRQ_MASK 12'h008
`define OFF_TASK_ERR 12'h00C
`define OFF_MODE_ERR 12'h010
`define OFF_SYNC_ERR 12'h014
`define OFF_PTP_ERR 12'h018
`define OFF_DISPLAY 12'h01C
`define OFF_TASK_AXES_BASE 12'h020
`define OFF_SEQ_LIMIT 12'h030
`define OFF_SEQ_LOAD 12'h034
`define OFF_TORQUE_LIM 12'h038
`define OFF_OFFSET_LIM 12'h03C
`define OFF_DECEL_MAX 12'h040
`define OFF_ROT_LIM 12'h044

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_ERR_RESET 0
`define SEQ_LOAD_STORED 8

// ----------------------------------------------------------------
// Reset values and fixed limits
// ----------------------------------------------------------------
`define TASK_AXES_RST 16'h0000
`define SEQ_LIMIT_RST 8'h63
`define TORQUE_LIM_RST 16'h03E8
`define OFFSET_LIM_RST 8'h0F
`define DECEL_MAX_RST 16'h7530
`define ROT_LIM_RST 32'h7FFFFFFF
`define IRQ_MASK_RST 7'h00
`define PTP_DIR_MAX 2'h2

`endif

//--- pkg/err_chk_pkg.sv
// Purpose: Types shared by the error checker modules
// Assumes: Four tasks, sixteen axes
// Notes: Constants live in err_chk_regs.svh
package err_chk_pkg;
	typedef enum logic [1:0] {
		DISP_NONE = 2'b00,
		DISP_AXIS = 2'b01,
		DISP_TASK = 2'b10
	} disp_kind_t;

	typedef enum logic [2:0] {
		IRQ_MULTI = 3'h0,
		IRQ_SEQ = 3'h1,
		IRQ_CFG = 3'h2,
		IRQ_MODE = 3'h3,
		IRQ_TORQUE = 3'h4,
		IRQ_OFFSET = 3'h5,
		IRQ_PTP = 3'h6
	} irq_bit_t;
endpackage

//--- pkg/task_fault_if.sv
// Purpose: Signals between the top and one task fault unit
// Assumes: Same clock on both sides
// Notes: err bits are {axis, sequence, multi-start}
`timescale 1ns/1ps
`default_nettype none
interface task_fault_if;
	logic start_all;
	logic start_one;
	logic seq_bad;
	logic busy;
	logic axerr;
	logic running;
	logic err_reset;
	logic [2:0] err;
	logic [2:0] evt;
	logic decel;

	modport unit (
		input start_all, start_one, seq_bad, busy, axerr, running,
		input err_reset,
		output err, evt, decel
	);
	modport top (
		output start_all, start_one, seq_bad, busy, axerr, running,
		output err_reset,
		input err, evt, decel
	);
endinterface
`default_nettype wire

//--- logic/task_fault_unit.sv
// Purpose: Latches the task-level errors of one memory-operation task
// Assumes: Start strobes are one-cycle pulses on pclk
// Notes: A new fault wins over an error reset in the same cycle
`timescale 1ns/1ps
`default_nettype none
module task_fault_unit (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Task signals
	task_fault_if.unit tf
);
	logic [2:0] err_q;
	logic [2:0] err_d;
	wire start_any = tf.start_all | tf.start_one;
	wire multi_hit = (tf.start_all & tf.start_one) |
		(start_any & tf.busy);
	wire seq_hit = start_any & tf.seq_bad;
	wire cfg_hit = tf.running & tf.axerr;
	wire [2:0] hit = {cfg_hit, seq_hit, multi_hit};

	assign err_d = (err_q & ~{3{tf.err_reset}}) | hit;
	assign tf.err = err_q;
	assign tf.evt = hit & ~err_q;
	assign tf.decel = |err_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			err_q <= 3'h0;
		end else begin
			err_q <= err_d;
		end
	end
endmodule
`default_nettype wire

//--- logic/motion_task_error_checker.sv
// Purpose: Error detection and stop control for a multi-axis controller
// Assumes: All inputs come from logic on pclk; APB slave with no wait
// Notes: Every latched error is cleared only by an error reset
`timescale 1ns/1ps
`default_nettype none
`include "err_chk_regs.svh"

// What this block does
// - Whole-task and individual start together flag a task multi-start error.
// - Starting a task while one of its axes is busy flags multi-start.
// - A sequence index beyond the allowed range flags a sequence error.
// - A sequence index with no stored data also flags a sequence error.
// - An axis error inside the running task flags a task axis error.
// - Any task error makes every axis of that task decelerate to stop.
// - A failed speed or torque mode stop flags a per-axis mode error.
// - Out-of-range synchronous feed torque command flags a per-axis error.
// - Invalid velocity-limit offset at feed start flags a per-axis error.
// - Bad high-speed point start settings decelerate that axis to stop.
module motion_task_error_checker (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Memory-operation starts, one bit per task
	input wire logic [3:0] mem_start_all,
	input wire logic [3:0] mem_start_one,
	input wire logic [7:0] seq_index,
	input wire logic [3:0] task_running,
	// Axis state
	input wire logic [15:0] axis_busy,
	input wire logic [15:0] axis_error,
	input wire logic [15:0] mode_stop_fail,
	// Synchronous feeding start
	input wire logic sync_start,
	input wire logic [3:0] sync_axis,
	input wire logic [15:0] sync_torque,
	input wire logic [7:0] sync_vlim_offset,
	// High-speed point start
	input wire logic ptp_start,
	input wire logic [3:0] ptp_axis,
	input wire logic [15:0] ptp_decel,
	input wire logic [1:0] ptp_dir,
	input wire logic [31:0] ptp_pos,
	// Stop commands and indicators
	output logic [15:0] axis_decel_stop,
	output logic unit_error_indicator,
	output logic [7:0] segment_status_display,
	output logic irq
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [15:0] task_axes_q [0:3];
	logic seq_stored_q [0:255];
	logic [7:0] seq_limit_q;
	logic [15:0] torque_lim_q;
	logic [7:0] offset_lim_q;
	logic [15:0] decel_max_q;
	logic [31:0] rot_lim_q;
	logic [6:0] irq_stat_q;
	logic [6:0] irq_mask_q;
	logic [15:0] mode_err_q;
	logic [15:0] torq_err_q;
	logic [15:0] offs_err_q;
	logic [15:0] ptp_err_q;
	logic [15:0] decel_q;
	logic [7:0] disp_q;
	logic [31:0] prdata_q;
	logic err_any_q;
	logic [3:0] multi_err;
	logic [3:0] seq_err;
	logic [3:0] cfg_err;
	logic [3:0] multi_evt;
	logic [3:0] seq_evt;
	logic [3:0] cfg_evt;
	logic [15:0] task_stop [0:3];

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	wire wr_en = psel & penable & pwrite;
	wire setup = psel & ~penable;
	// Task axis words sit at four consecutive offsets
	wire in_axes = paddr[11:4] == `OFF_TASK_AXES_BASE >> 4;
	wire [1:0] axes_sel = paddr[3:2];
	wire sel_ctrl = paddr == `OFF_CTRL;
	wire sel_istat = paddr == `OFF_IRQ_STAT;
	wire sel_imask = paddr == `OFF_IRQ_MASK;
	wire sel_terr = paddr == `OFF_TASK_ERR;
	wire sel_merr = paddr == `OFF_MODE_ERR;
	wire sel_serr = paddr == `OFF_SYNC_ERR;
	wire sel_perr = paddr == `OFF_PTP_ERR;
	wire sel_disp = paddr == `OFF_DISPLAY;
	wire sel_axes = in_axes & (paddr[1:0] == 2'h0);
	wire sel_slim = paddr == `OFF_SEQ_LIMIT;
	wire sel_sload = paddr == `OFF_SEQ_LOAD;
	wire sel_tlim = paddr == `OFF_TORQUE_LIM;
	wire sel_olim = paddr == `OFF_OFFSET_LIM;
	wire sel_dmax = paddr == `OFF_DECEL_MAX;
	wire sel_rlim = paddr == `OFF_ROT_LIM;
	wire addr_ok = sel_ctrl | sel_istat | sel_imask | sel_terr |
		sel_merr | sel_serr | sel_perr | sel_disp | sel_axes |
		sel_slim | sel_sload | sel_tlim | sel_olim | sel_dmax |
		sel_rlim;

	// Error reset is a write of one to the control bit
	wire err_reset = wr_en & sel_ctrl & pwdata[`CTRL_ERR_RESET];
	wire istat_clr = wr_en & sel_istat;

	wire [31:0] rd_mux =
		sel_istat ? {25'h0, irq_stat_q} :
		sel_imask ? {25'h0, irq_mask_q} :
		sel_terr ? {20'h0, cfg_err, seq_err, multi_err} :
		sel_merr ? {16'h0, mode_err_q} :
		sel_serr ? {offs_err_q, torq_err_q} :
		sel_perr ? {16'h0, ptp_err_q} :
		sel_disp ? {24'h0, disp_q} :
		sel_axes ? {16'h0, task_axes_q[axes_sel]} :
		sel_slim ? {24'h0, seq_limit_q} :
		sel_tlim ? {16'h0, torque_lim_q} :
		sel_olim ? {24'h0, offset_lim_q} :
		sel_dmax ? {16'h0, decel_max_q} :
		sel_rlim ? rot_lim_q :
		32'h0;

	// Zero wait states; read data was captured in the setup cycle
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;
	assign prdata = prdata_q;

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_limit_q <= `SEQ_LIMIT_RST;
			torque_lim_q <= `TORQUE_LIM_RST;
			offset_lim_q <= `OFFSET_LIM_RST;
			decel_max_q <= `DECEL_MAX_RST;
			rot_lim_q <= `ROT_LIM_RST;
			irq_mask_q <= `IRQ_MASK_RST;
			prdata_q <= 32'h0;
		end else begin
			if (wr_en & sel_slim) seq_limit_q <= pwdata[7:0];
			if (wr_en & sel_tlim) torque_lim_q <= pwdata[15:0];
			if (wr_en & sel_olim) offset_lim_q <= pwdata[7:0];
			if (wr_en & sel_dmax) decel_max_q <= pwdata[15:0];
			if (wr_en & sel_rlim) rot_lim_q <= pwdata;
			if (wr_en & sel_imask) irq_mask_q <= pwdata[6:0];
			if (setup & ~pwrite) prdata_q <= rd_mux;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int t = 0; t < 4; t++) begin
				task_axes_q[t] <= `TASK_AXES_RST;
			end
		end else if (wr_en & sel_axes) begin
			task_axes_q[axes_sel] <= pwdata[15:0];
		end
	end

	// ----------------------------------------------------------------
	// Stored-sequence table
	// ----------------------------------------------------------------
	// Software marks which sequence indices hold data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 256; i++) begin
				seq_stored_q[i] <= 1'b0;
			end
		end else if (wr_en & sel_sload) begin
			seq_stored_q[pwdata[7:0]] <= pwdata[`SEQ_LOAD_STORED];
		end
	end

	// ----------------------------------------------------------------
	// Task checks
	// ----------------------------------------------------------------
	// One shared sequence index serves all four tasks
	wire seq_bad = (seq_index > seq_limit_q) |
		~seq_stored_q[seq_index];

	// One fault unit per task; each stops only the axes of its task
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_task
			task_fault_if tif ();
			assign tif.start_all = mem_start_all[g];
			assign tif.start_one = mem_start_one[g];
			assign tif.seq_bad = seq_bad;
			assign tif.busy = |(axis_busy & task_axes_q[g]);
			assign tif.axerr = |(axis_error & task_axes_q[g]);
			assign tif.running = task_running[g];
			assign tif.err_reset = err_reset;
			assign multi_err[g] = tif.err[0];
			assign seq_err[g] = tif.err[1];
			assign cfg_err[g] = tif.err[2];
			assign multi_evt[g] = tif.evt[0];
			assign seq_evt[g] = tif.evt[1];
			assign cfg_evt[g] = tif.evt[2];
			assign task_stop[g] = tif.decel ? task_axes_q[g] : 16'h0;
			task_fault_unit u_unit (
				.clk(pclk),
				.rst_n(presetn),
				.tf(tif.unit)
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Per-axis checks
	// ----------------------------------------------------------------
	// Axis numbers 0 to 15 select one bit of the axis masks
	wire [15:0] sync_sel = 16'h0001 << sync_axis;
	wire [15:0] ptp_sel = 16'h0001 << ptp_axis;
	wire torq_bad = sync_torque > torque_lim_q;
	wire offs_bad = sync_vlim_offset > offset_lim_q;
	// Any bad point-start setting stops that axis
	wire ptp_decel_bad = (ptp_decel == 16'h0) |
		(ptp_decel > decel_max_q);
	wire ptp_dir_bad = ptp_dir > `PTP_DIR_MAX;
	wire ptp_pos_bad = ptp_pos > rot_lim_q;
	wire ptp_bad = ptp_decel_bad | ptp_dir_bad | ptp_pos_bad;
	wire [15:0] torq_hit = (sync_start & torq_bad) ? sync_sel : 16'h0;
	wire [15:0] offs_hit = (sync_start & offs_bad) ? sync_sel : 16'h0;
	wire [15:0] ptp_hit = (ptp_start & ptp_bad) ? ptp_sel : 16'h0;
	wire [15:0] keep = ~{16{err_reset}};

	// ----------------------------------------------------------------
	// Per-axis error latches
	// ----------------------------------------------------------------
	// A new fault wins over an error reset in the same cycle

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_err_q <= 16'h0;
			torq_err_q <= 16'h0;
			offs_err_q <= 16'h0;
			ptp_err_q <= 16'h0;
		end else begin
			mode_err_q <= (mode_err_q & keep) | mode_stop_fail;
			torq_err_q <= (torq_err_q & keep) | torq_hit;
			offs_err_q <= (offs_err_q & keep) | offs_hit;
			ptp_err_q <= (ptp_err_q & keep) | ptp_hit;
		end
	end

	// ----------------------------------------------------------------
	// Stop commands
	// ----------------------------------------------------------------
	// Task stops and point-start stops merge into one registered command
	wire [15:0] stop_d = task_stop[0] | task_stop[1] | task_stop[2] |
		task_stop[3] | ptp_err_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			decel_q <= 16'h0;
		end else begin
			decel_q <= stop_d;
		end
	end

	assign axis_decel_stop = decel_q;

	// ----------------------------------------------------------------
	// Interrupt status
	// ----------------------------------------------------------------
	wire [6:0] irq_evt = {
		|(ptp_hit & ~ptp_err_q),
		|(offs_hit & ~offs_err_q),
		|(torq_hit & ~torq_err_q),
		|(mode_stop_fail & ~mode_err_q),
		|cfg_evt,
		|seq_evt,
		|multi_evt
	};
	// A new event wins over a write-one clear in the same cycle
	wire [6:0] istat_keep = istat_clr ? ~pwdata[6:0] : 7'h7F;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= 7'h0;
		end else begin
			irq_stat_q <= (irq_stat_q & istat_keep) | irq_evt;
		end
	end

	// Level output, high while any unmasked status bit is set
	assign irq = |(irq_stat_q & irq_mask_q);

	// ----------------------------------------------------------------
	// Status display
	// ----------------------------------------------------------------
	wire [15:0] axis_any = mode_err_q | torq_err_q | offs_err_q |
		ptp_err_q;
	wire [3:0] task_any = multi_err | seq_err | cfg_err;
	logic [7:0] disp_d;

	// Lowest faulty axis first, then lowest faulty task
	always_comb begin
		disp_d = {err_chk_pkg::DISP_NONE, 6'h00};
		for (int t = 3; t >= 0; t--) begin
			if (task_any[t]) begin
				disp_d = {err_chk_pkg::DISP_TASK, 1'b0,
					5'(t + 1)};
			end
		end
		for (int a = 15; a >= 0; a--) begin
			if (axis_any[a]) begin
				disp_d = {err_chk_pkg::DISP_AXIS, 1'b0,
					5'(a + 1)};
			end
		end
	end

	// ----------------------------------------------------------------
	// Display and indicator registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			disp_q <= 8'h00;
			err_any_q <= 1'b0;
		end else begin
			disp_q <= disp_d;
			err_any_q <= (|axis_any) | (|task_any);
		end
	end

	assign segment_status_display = disp_q;
	assign unit_error_indicator = err_any_q;

endmodule
`default_nettype wire

//--- test/err_chk_sva.sv
// Purpose: Port assertions for the error checker
// Assumes: Limit registers hold their reset values
// Notes: Bound to the top module below
`timescale 1ns/1ps
`default_nettype none
`include "err_chk_regs.svh"
module err_chk_sva (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Stimulus
	input wire logic psel,
	input wire logic penable,
	input wire logic [3:0] mem_start_all,
	input wire logic [3:0] mem_start_one,
	input wire logic [7:0] seq_index,
	input wire logic [15:0] mode_stop_fail,
	input wire logic sync_start,
	input wire logic [15:0] sync_torque,
	input wire logic [7:0] sync_vlim_offset,
	input wire logic ptp_start,
	input wire logic [3:0] ptp_axis,
	input wire logic [15:0] ptp_decel,
	// Results
	input wire logic pready,
	input wire logic [15:0] axis_decel_stop,
	input wire logic unit_error_indicator,
	input wire logic [7:0] segment_status_display
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_dual;
		|(mem_start_all & mem_start_one);
	endsequence
	sequence s_shown;
		##2 unit_error_indicator;
	endsequence
	property p_multi;
		s_dual |-> s_shown;
	endproperty
	a_multi: assert property (p_multi)
		else $error("multi-start not flagged");
	property p_seq;
		(|(mem_start_all | mem_start_one)) && seq_index > `SEQ_LIMIT_RST
			|-> s_shown;
	endproperty
	a_seq: assert property (p_seq)
		else $error("sequence range not flagged");
	property p_mode;
		|mode_stop_fail |-> s_shown;
	endproperty
	a_mode: assert property (p_mode)
		else $error("mode stop failure not flagged");
	property p_torque;
		sync_start && sync_torque > `TORQUE_LIM_RST |-> s_shown;
	endproperty
	a_torque: assert property (p_torque)
		else $error("torque not flagged");
	property p_offset;
		sync_start && sync_vlim_offset > `OFFSET_LIM_RST |-> s_shown;
	endproperty
	a_offset: assert property (p_offset)
		else $error("offset not flagged");
	property p_ptp;
		ptp_start && ptp_decel == 16'h0000
			|-> ##2 axis_decel_stop[$past(ptp_axis, 2)];
	endproperty
	a_ptp: assert property (p_ptp)
		else $error("point start axis not stopped");
	property p_stop;
		|axis_decel_stop |-> unit_error_indicator;
	endproperty
	a_stop: assert property (p_stop)
		else $error("stop without latched error");
	property p_disp;
		unit_error_indicator |-> segment_status_display[7:6] != 2'b00
			&& segment_status_display[4:0] inside {[1:16]};
	endproperty
	a_disp: assert property (p_disp)
		else $error("display code out of range");
	property p_blank;
		!unit_error_indicator |-> segment_status_display == 8'h00;
	endproperty
	a_blank: assert property (p_blank)
		else $error("display not blank");
	property p_ready;
		psel && penable |-> pready;
	endproperty
	a_ready: assert property (p_ready)
		else $error("access not answered");
endmodule
bind motion_task_error_checker err_chk_sva u_sva (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable),
	.mem_start_all(mem_start_all), .mem_start_one(mem_start_one),
	.seq_index(seq_index), .mode_stop_fail(mode_stop_fail),
	.sync_start(sync_start), .sync_torque(sync_torque),
	.sync_vlim_offset(sync_vlim_offset), .ptp_start(ptp_start),
	.ptp_axis(ptp_axis), .ptp_decel(ptp_decel), .pready(pready),
	.axis_decel_stop(axis_decel_stop),
	.unit_error_indicator(unit_error_indicator),
	.segment_status_display(segment_status_display));
`default_nettype wire

//--- test/host_start_model.sv
// Purpose: Host side issuing memory-operation start strobes
// Assumes: Strobes last one pclk cycle
// Notes: Index is scrambled once the strobe is gone
`timescale 1ns/1ps
`default_nettype none
module host_start_model (
	// Clock
	input wire logic pclk,
	// Start strobes
	output logic [3:0] mem_start_all,
	output logic [3:0] mem_start_one,
	output logic [7:0] seq_index
);
	initial begin
		mem_start_all = 4'h0;
		mem_start_one = 4'h0;
		seq_index = 8'h00;
	end
	task automatic start(input logic [3:0] a, input logic [3:0] o,
		input logic [7:0] s);
		@(posedge pclk);
		mem_start_all <= a;
		mem_start_one <= o;
		seq_index <= s;
		@(posedge pclk);
		mem_start_all <= 4'h0;
		mem_start_one <= 4'h0;
		seq_index <= ~s;
	endtask
endmodule
`default_nettype wire

//--- test/motion_task_error_checker_tb.sv
// Purpose: Self-checking bench of the error checker
// Assumes: Zero-wait APB slave
// Notes: One task per scenario
`timescale 1ns/1ps
`default_nettype none
`include "err_chk_regs.svh"
module motion_task_error_checker_tb;
	logic pclk = 1'b0, presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, serr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, unit_error_indicator, irq;
	logic [3:0] mem_start_all, mem_start_one, task_running = 4'h0;
	logic [7:0] seq_index, segment_status_display;
	logic [15:0] axis_busy = 16'h0, axis_error = 16'h0, axis_decel_stop;
	logic [15:0] mode_stop_fail = 16'h0, sync_torque = 16'h0;
	logic sync_start = 1'b0, ptp_start = 1'b0;
	logic [3:0] sync_axis = 4'h0, ptp_axis = 4'h0;
	logic [7:0] sync_vlim_offset = 8'h00;
	logic [15:0] ptp_decel = 16'h0100;
	logic [1:0] ptp_dir = 2'h0;
	logic [31:0] ptp_pos = 32'h0;
	int error_cnt = 0, total_checks = 0, cyc = 0;
	always #25 pclk = ~pclk;
	host_start_model host (.pclk(pclk), .mem_start_all(mem_start_all),
		.mem_start_one(mem_start_one), .seq_index(seq_index));
	motion_task_error_checker dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mem_start_all(mem_start_all),
		.mem_start_one(mem_start_one), .seq_index(seq_index),
		.task_running(task_running), .axis_busy(axis_busy),
		.axis_error(axis_error), .mode_stop_fail(mode_stop_fail),
		.sync_start(sync_start), .sync_axis(sync_axis),
		.sync_torque(sync_torque), .sync_vlim_offset(sync_vlim_offset),
		.ptp_start(ptp_start), .ptp_axis(ptp_axis), .ptp_decel(ptp_decel),
		.ptp_dir(ptp_dir), .ptp_pos(ptp_pos),
		.axis_decel_stop(axis_decel_stop),
		.unit_error_indicator(unit_error_indicator),
		.segment_status_display(segment_status_display), .irq(irq));
	task automatic complete_run;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			complete_run();
		end
	end
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rchk(input string n, input logic [11:0] a,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(n, e, rd);
	endtask
	task automatic clr;
		apb(1'b1, `OFF_CTRL, 32'h1);
		apb(1'b1, `OFF_IRQ_STAT, 32'h7F);
		@(posedge pclk);
		chk("clear", 32'h0, {30'h0, unit_error_indicator, irq});
	endtask
	task automatic sync(input logic [3:0] a, input logic [15:0] t,
		input logic [7:0] o);
		sync_axis <= a;
		sync_torque <= t;
		sync_vlim_offset <= o;
		sync_start <= 1'b1;
		@(posedge pclk);
		sync_start <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic ptp(input logic [3:0] a, input logic [15:0] d,
		input logic [1:0] r, input logic [31:0] p);
		ptp_axis <= a;
		ptp_decel <= d;
		ptp_dir <= r;
		ptp_pos <= p;
		ptp_start <= 1'b1;
		@(posedge pclk);
		ptp_start <= 1'b0;
		ptp_decel <= 16'h0100;
		ptp_dir <= 2'h0;
		ptp_pos <= 32'h0;
		@(posedge pclk);
	endtask
	task automatic t_regs;
		rchk("seq_limit", `OFF_SEQ_LIMIT, 32'h63);
		rchk("torque_lim", `OFF_TORQUE_LIM, 32'h3E8);
		rchk("unmapped", 12'h100, 32'h0);
		chk("slverr", 32'h1, {31'h0, serr});
		$display("regs done");
	endtask
	task automatic t_multi;
		apb(1'b1, `OFF_IRQ_MASK, 32'h7F);
		apb(1'b1, `OFF_TASK_AXES_BASE, 32'h3);
		apb(1'b1, `OFF_SEQ_LOAD, 32'h105);
		host.start(4'h1, 4'h1, 8'h05);
		rchk("multi", `OFF_TASK_ERR, 32'h1);
		chk("stop", 32'h3, {16'h0, axis_decel_stop});
		chk("disp", 32'h81, {24'h0, segment_status_display});
		chk("irq", 32'h1, {31'h0, irq});
		chk("ind", 32'h1, {31'h0, unit_error_indicator});
		clr();
		axis_busy <= 16'h0010;
		apb(1'b1, `OFF_TASK_AXES_BASE + 12'h4, 32'h10);
		host.start(4'h2, 4'h0, 8'h05);
		rchk("busy", `OFF_TASK_ERR, 32'h2);
		chk("stop", 32'h10, {16'h0, axis_decel_stop});
		axis_busy <= 16'h0;
		clr();
		$display("multi done");
	endtask
	task automatic t_seq;
		apb(1'b1, `OFF_SEQ_LOAD, 32'h163);
		host.start(4'h4, 4'h0, 8'h63);
		rchk("limit", `OFF_TASK_ERR, 32'h0);
		host.start(4'h0, 4'h4, 8'h64);
		rchk("range", `OFF_TASK_ERR, 32'h40);
		chk("disp", 32'h83, {24'h0, segment_status_display});
		clr();
		host.start(4'h0, 4'h4, 8'h07);
		rchk("empty", `OFF_TASK_ERR, 32'h40);
		clr();
		$display("seq done");
	endtask
	task automatic t_cfg;
		apb(1'b1, `OFF_TASK_AXES_BASE + 12'hC, 32'h100);
		axis_error <= 16'h0100;
		repeat (2) @(posedge pclk);
		rchk("idle", `OFF_TASK_ERR, 32'h0);
		task_running <= 4'h8;
		repeat (2) @(posedge pclk);
		rchk("cfg", `OFF_TASK_ERR, 32'h800);
		chk("stop", 32'h100, {16'h0, axis_decel_stop});
		task_running <= 4'h0;
		axis_error <= 16'h0;
		clr();
		$display("cfg done");
	endtask
	task automatic t_axis;
		mode_stop_fail <= 16'h0004;
		@(posedge pclk);
		mode_stop_fail <= 16'h0;
		rchk("mode", `OFF_MODE_ERR, 32'h4);
		chk("disp", 32'h43, {24'h0, segment_status_display});
		rchk("istat", `OFF_IRQ_STAT, 32'h8);
		apb(1'b1, `OFF_IRQ_MASK, 32'h77);
		@(posedge pclk);
		chk("irq_mask", 32'h0, {31'h0, irq});
		apb(1'b1, `OFF_IRQ_MASK, 32'h7F);
		clr();
		sync(4'h4, 16'h3E8, 8'h0F);
		sync(4'h5, 16'h3E9, 8'h00);
		sync(4'h6, 16'h000, 8'h10);
		rchk("sync", `OFF_SYNC_ERR, 32'h0040_0020);
		clr();
		ptp(4'h9, 16'h0000, 2'h0, 32'h0);
		ptp(4'h1, 16'h7531, 2'h0, 32'h0);
		ptp(4'h2, 16'h7530, 2'h3, 32'h0);
		ptp(4'h3, 16'h7530, 2'h2, 32'h8000_0000);
		ptp(4'h4, 16'h7530, 2'h2, 32'h7FFF_FFFF);
		rchk("ptp", `OFF_PTP_ERR, 32'h20E);
		chk("ptp_stop", 32'h20E, {16'h0, axis_decel_stop});
		clr();
		$display("axis done");
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_multi();
		t_seq();
		t_cfg();
		t_axis();
		complete_run();
	end
endmodule
`default_nettype wire
